// file: hw/timer16_consts.vh
// constants shared by the 16-bit timer mode and capture control block
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH

// ==========================================
// register indices; the byte address is four times the index
`define IDX_CONTROL_A 8'h80
`define IDX_CONTROL_B 8'h81
`define IDX_COUNTER 8'h84
`define IDX_CAPTURE 8'h86
`define IDX_COMPARE_A 8'h88
`define IDX_COMPARE_B 8'h8A
`define IDX_INT_STATUS 8'hC0
`define IDX_INT_MASK 8'hC1

// ==========================================
// control register field positions
`define CTLA_MODE_LO 1:0
`define CTLA_OUTMODE 7:4
`define CTLB_CLKSEL 2:0
`define CTLB_MODE_HI 4:3
`define CTLB_EDGE 6
`define CTLB_FILTER 7
`define CTLA_RW_MASK 8'hF3
`define CTLB_RW_MASK 8'hDF
`define CTL_RESET 8'h00
`define WORD_RESET 16'h0000

// ==========================================
// interrupt status and mask bit positions
`define IRQ_OVERFLOW 0
`define IRQ_CAPTURE 1
`define IRQ_MATCH_A 2
`define IRQ_MATCH_B 3
`define IRQ_WIDTH 4

// ==========================================
// fixed top values and counter extremes
`define TOP_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define BOTTOM 16'h0000

// ==========================================
// clock select codes and prescaler masks
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
`define PRE_MASK8 10'h007
`define PRE_MASK64 10'h03F
`define PRE_MASK256 10'h0FF
`define PRE_MASK1024 10'h3FF

// ==========================================
// capture filter length in samples
`define FILTER_SAMPLES 4

`endif

// file: hw/capture_filter.v
// capture input noise filter: output follows only a run of equal samples
`timescale 1ns/1ps
`include "timer16_consts.vh"

module capture_filter #(
    parameter SAMPLES = `FILTER_SAMPLES
) (
    input wire hclk,
    input wire hresetn,
    input wire sample_in,
    output reg filtered_out
);

    reg [SAMPLES-1:0] history_reg;
    wire all_high;
    wire all_low;

    // ==========================================
    // sample history
    // shift in one sample per clock
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            history_reg <= {SAMPLES{1'b0}};
        end else begin
            history_reg <= {history_reg[SAMPLES-2:0], sample_in};
        end
    end

    // output flips only after SAMPLES equal samples in a row
    assign all_high = &history_reg;
    assign all_low = ~|history_reg;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filtered_out <= 1'b0;
        end else if (all_high) begin
            filtered_out <= 1'b1;
        end else if (all_low) begin
            filtered_out <= 1'b0;
        end
    end

endmodule // capture_filter

// file: hw/timer16_mode_and_capture_ctrl.v
// 16-bit timer with waveform mode decode and input capture, AHB-Lite slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "timer16_consts.vh"

module timer16_mode_and_capture_ctrl #(
    parameter WIDTH = 16,
    parameter PRE_WIDTH = 10
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire capture_input_pin,
    input wire ext_clock_pin,
    output reg irq
);

    // ==========================================
    // declarations
    reg [7:0] control_a_reg;
    reg [7:0] control_b_reg;
    reg [WIDTH-1:0] counter_value_reg;
    reg [WIDTH-1:0] counter_value_next;
    reg [WIDTH-1:0] capture_register_reg;
    reg [WIDTH-1:0] compare_a_buf_reg;
    reg [WIDTH-1:0] compare_b_buf_reg;
    reg [WIDTH-1:0] compare_a_reg;
    reg [WIDTH-1:0] compare_b_reg;
    reg [`IRQ_WIDTH-1:0] int_status_reg;
    reg [`IRQ_WIDTH-1:0] int_mask_reg;
    reg [PRE_WIDTH-1:0] prescale_reg;
    reg count_down_reg;
    reg count_down_next;
    reg ext_prev_reg;
    reg pin_sample_reg;
    reg edge_prev_reg;
    reg wr_pending_reg;
    reg [7:0] wr_index_reg;
    reg [WIDTH-1:0] top_value;
    reg tick;
    reg load_compare;
    reg overflow_event;
    reg [31:0] read_word;
    reg [`IRQ_WIDTH-1:0] event_bits;
    wire [3:0] wave_mode_field;
    wire filtered_pin;
    wire edge_source;
    wire capture_edge;
    wire capture_is_top;
    wire family_phase;
    wire family_pfc;
    wire family_fast;
    wire addr_phase;
    wire [7:0] addr_index;
    wire [2:0] clock_select;

    // ==========================================
    // mode decode
    // mode value split across the two control registers
    assign wave_mode_field = {control_b_reg[`CTLB_MODE_HI], control_a_reg[`CTLA_MODE_LO]};
    assign clock_select = control_b_reg[`CTLB_CLKSEL];

    // counting family; mode 13 falls into none and counts like normal
    // reserved mode 13 gives no waveform; software is expected to avoid it
    assign family_phase = (wave_mode_field >= 4'h1 && wave_mode_field <= 4'h3) ||
                          wave_mode_field == 4'hA || wave_mode_field == 4'hB;
    assign family_fast = (wave_mode_field >= 4'h5 && wave_mode_field <= 4'h7) ||
                         wave_mode_field == 4'hE || wave_mode_field == 4'hF;
    assign family_pfc = wave_mode_field == 4'h8 || wave_mode_field == 4'h9;
    // modes whose top comes from the capture register
    // the even modes from 8 up; the pin is cut off in all of them
    assign capture_is_top = wave_mode_field == 4'h8 || wave_mode_field == 4'hA ||
                            wave_mode_field == 4'hC || wave_mode_field == 4'hE;

    // top value source by mode
    // clear-on-compare tests equality, so a top written below the count
    // lets the counter run on to max and wrap before the new top holds
    always @* begin
        case (wave_mode_field)
            4'h1, 4'h5: top_value = `TOP_8BIT;
            4'h2, 4'h6: top_value = `TOP_9BIT;
            4'h3, 4'h7: top_value = `TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top_value = compare_a_reg;
            4'h8, 4'hA, 4'hC, 4'hE: top_value = capture_register_reg;
            default: top_value = `TOP_MAX;
        endcase
    end

    // ==========================================
    // clock select and prescaler
    // free running prescaler, held at zero while stopped to save toggling
    // restarting from zero puts the first divided tick a full period out
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale_reg <= {PRE_WIDTH{1'b0}};
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_clock_pin;
            if (clock_select == `CS_STOP) begin
                prescale_reg <= {PRE_WIDTH{1'b0}};
            end else begin
                prescale_reg <= prescale_reg + 1'b1;
            end
        end
    end

    // timer tick; dividers fire when the low prescaler bits are all ones
    // external edges are seen in the cycle the pin changes, against the previous-level flop
    always @* begin
        case (clock_select)
            `CS_DIV1: tick = 1'b1;
            `CS_DIV8: tick = (prescale_reg & `PRE_MASK8) == `PRE_MASK8;
            `CS_DIV64: tick = (prescale_reg & `PRE_MASK64) == `PRE_MASK64;
            `CS_DIV256: tick = (prescale_reg & `PRE_MASK256) == `PRE_MASK256;
            `CS_DIV1024: tick = (prescale_reg & `PRE_MASK1024) == `PRE_MASK1024;
            `CS_EXT_FALL: tick = ext_prev_reg & ~ext_clock_pin;
            `CS_EXT_RISE: tick = ~ext_prev_reg & ext_clock_pin;
            default: tick = 1'b0;
        endcase
    end

    // ==========================================
    // counting sequence
    // up/down for phase families, single slope otherwise
    // a counter write leaves the direction flop alone, so a phase mode
    // resumes in whichever direction it last had
    always @* begin
        counter_value_next = counter_value_reg;
        count_down_next = count_down_reg;
        load_compare = ~(family_phase | family_pfc | family_fast);
        overflow_event = 1'b0;
        if (tick) begin
            if (family_phase || family_pfc) begin
                // turn at top and bottom; overflow sets at the bottom turn
                if (!count_down_reg) begin
                    if (counter_value_reg >= top_value) begin
                        count_down_next = 1'b1;
                        counter_value_next = counter_value_reg - 1'b1;
                        load_compare = family_phase;
                    end else begin
                        counter_value_next = counter_value_reg + 1'b1;
                    end
                end else if (counter_value_reg == `BOTTOM) begin
                    count_down_next = 1'b0;
                    counter_value_next = counter_value_reg + 1'b1;
                    overflow_event = 1'b1;
                    load_compare = family_pfc;
                end else begin
                    counter_value_next = counter_value_reg - 1'b1;
                end
            end else if (family_fast) begin
                // >= lets a top written below the count wrap at once
                if (counter_value_reg >= top_value) begin
                    counter_value_next = `BOTTOM;
                    overflow_event = 1'b1;
                    load_compare = 1'b1;
                end else begin
                    counter_value_next = counter_value_reg + 1'b1;
                end
            end else begin
                // normal and clear-on-compare: overflow only on wrap from max
                overflow_event = counter_value_reg == `TOP_MAX;
                if (counter_value_reg == top_value) begin
                    counter_value_next = `BOTTOM;
                end else begin
                    counter_value_next = counter_value_reg + 1'b1;
                end
            end
        end
    end

    // ==========================================
    // capture input path
    // filter runs all the time, so enabling it meets a settled history
    capture_filter #(
        .SAMPLES(`FILTER_SAMPLES)
    ) u_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .sample_in(capture_input_pin),
        .filtered_out(filtered_pin)
    );

    // raw sample register keeps the unfiltered path one flop apart from the pin
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_sample_reg <= 1'b0;
            edge_prev_reg <= 1'b0;
        end else begin
            pin_sample_reg <= capture_input_pin;
            edge_prev_reg <= edge_source;
        end
    end

    // path chosen ahead of the edge detector, which both paths share
    assign edge_source = control_b_reg[`CTLB_FILTER] ? filtered_pin : pin_sample_reg;
    // edge polarity, gated off when capture register is the top
    assign capture_edge = ~capture_is_top &
                          (control_b_reg[`CTLB_EDGE] ? (edge_source & ~edge_prev_reg)
                                                     : (~edge_source & edge_prev_reg));

    // ==========================================
    // bus slave: address phase capture
    assign addr_phase = hsel & htrans[1] & hready;
    assign addr_index = haddr[9:2];

    // write data arrives one cycle after the address; remember the target
    // zero wait states: ready and okay are constant flops, no stall
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending_reg <= 1'b0;
            wr_index_reg <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pending_reg <= addr_phase & hwrite;
            wr_index_reg <= addr_index;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read mux; unmapped and reserved bits read zero
    // compare offsets return the buffers, not the active values
    always @* begin
        read_word = 32'h0000_0000;
        case (addr_index)
            `IDX_CONTROL_A: read_word[7:0] = control_a_reg;
            `IDX_CONTROL_B: read_word[7:0] = control_b_reg;
            `IDX_COUNTER: read_word[WIDTH-1:0] = counter_value_reg;
            `IDX_CAPTURE: read_word[WIDTH-1:0] = capture_register_reg;
            `IDX_COMPARE_A: read_word[WIDTH-1:0] = compare_a_buf_reg;
            `IDX_COMPARE_B: read_word[WIDTH-1:0] = compare_b_buf_reg;
            `IDX_INT_STATUS: read_word[`IRQ_WIDTH-1:0] = int_status_reg;
            `IDX_INT_MASK: read_word[`IRQ_WIDTH-1:0] = int_mask_reg;
            default: read_word = 32'h0000_0000;
        endcase
    end

    // read data registered at the address phase, valid in the data phase
    // held until the next read, so a late sample still sees it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= read_word;
        end
    end

    // ==========================================
    // control and data registers
    // software writes take priority over counting and capture in the same cycle
    // a counter write therefore swallows the tick of that cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_a_reg <= `CTL_RESET;
            control_b_reg <= `CTL_RESET;
            counter_value_reg <= `WORD_RESET;
            count_down_reg <= 1'b0;
            capture_register_reg <= `WORD_RESET;
            compare_a_buf_reg <= `WORD_RESET;
            compare_b_buf_reg <= `WORD_RESET;
            compare_a_reg <= `WORD_RESET;
            compare_b_reg <= `WORD_RESET;
            int_mask_reg <= {`IRQ_WIDTH{1'b0}};
        end else begin
            count_down_reg <= count_down_next;
            if (wr_pending_reg && wr_index_reg == `IDX_COUNTER) begin
                counter_value_reg <= hwdata[WIDTH-1:0];
            end else begin
                counter_value_reg <= counter_value_next;
            end
            if (wr_pending_reg && wr_index_reg == `IDX_CAPTURE) begin
                capture_register_reg <= hwdata[WIDTH-1:0];
            end else if (capture_edge) begin
                capture_register_reg <= counter_value_reg;
            end
            if (load_compare) begin
                compare_a_reg <= compare_a_buf_reg;
                compare_b_reg <= compare_b_buf_reg;
            end
            if (wr_pending_reg) begin
                case (wr_index_reg)
                    `IDX_CONTROL_A: control_a_reg <= hwdata[7:0] & `CTLA_RW_MASK;
                    `IDX_CONTROL_B: control_b_reg <= hwdata[7:0] & `CTLB_RW_MASK;
                    `IDX_COMPARE_A: compare_a_buf_reg <= hwdata[WIDTH-1:0];
                    `IDX_COMPARE_B: compare_b_buf_reg <= hwdata[WIDTH-1:0];
                    `IDX_INT_MASK: int_mask_reg <= hwdata[`IRQ_WIDTH-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ==========================================
    // interrupt status, mask and output
    // match events need a tick, so a stopped timer raises none
    always @* begin
        event_bits = {`IRQ_WIDTH{1'b0}};
        event_bits[`IRQ_OVERFLOW] = overflow_event;
        event_bits[`IRQ_CAPTURE] = capture_edge;
        event_bits[`IRQ_MATCH_A] = tick & (counter_value_reg == compare_a_reg);
        event_bits[`IRQ_MATCH_B] = tick & (counter_value_reg == compare_b_reg);
    end

    // write-one-to-clear; a new event in the clear cycle keeps its bit
    // irq is one flop behind the status, so the pin never glitches
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_status_reg <= {`IRQ_WIDTH{1'b0}};
            irq <= 1'b0;
        end else begin
            if (wr_pending_reg && wr_index_reg == `IDX_INT_STATUS) begin
                int_status_reg <= (int_status_reg & ~hwdata[`IRQ_WIDTH-1:0]) | event_bits;
            end else begin
                int_status_reg <= int_status_reg | event_bits;
            end
            irq <= |(int_status_reg & int_mask_reg);
        end
    end

endmodule // timer16_mode_and_capture_ctrl

// file: tb/timer16_properties.sv
// concurrent checks of bus answers, readback and capture timing at the timer ports
`timescale 1ns/1ps
`include "timer16_consts.vh"
module timer16_properties (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire capture_input_pin,
    input wire irq
);
    // ==========================================
    // shadows of the control and mask registers, taken from the bus
    reg wr_pend;
    reg [7:0] wr_idx;
    reg [7:0] ca_sh;
    reg [7:0] cb_sh;
    reg [3:0] mask_sh;
    wire take = hsel && htrans[1] && hready;
    wire [7:0] ai = haddr[9:2];
    wire [3:0] mode = {cb_sh[4:3], ca_sh[1:0]};
    // capture register as top: modes 8, 10, 12, 14
    wire top_cap = mode[3] && !mode[0];
    // only the capture source unmasked and quiet, so irq moves only on capture
    wire arm = (mask_sh == 4'h2) && !irq;
    wire filt = cb_sh[7];
    wire rise = cb_sh[6];
    wire mapped = (ai == `IDX_CONTROL_A) || (ai == `IDX_CONTROL_B) || (ai == `IDX_COUNTER) ||
        (ai == `IDX_CAPTURE) || (ai == `IDX_COMPARE_A) || (ai == `IDX_COMPARE_B) ||
        (ai == `IDX_INT_STATUS) || (ai == `IDX_INT_MASK);
    // registers follow the data phase one edge after the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
            ca_sh <= 8'h00;
            cb_sh <= 8'h00;
            mask_sh <= 4'h0;
        end else begin
            wr_pend <= take && hwrite;
            wr_idx <= ai;
            if (wr_pend && wr_idx == `IDX_CONTROL_A) ca_sh <= hwdata[7:0];
            if (wr_pend && wr_idx == `IDX_CONTROL_B) cb_sh <= hwdata[7:0];
            if (wr_pend && wr_idx == `IDX_INT_MASK) mask_sh <= hwdata[3:0];
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_wr(logic [7:0] i);
        take && hwrite && ai == i;
    endsequence
    sequence s_rd(logic [7:0] i);
        take && !hwrite && ai == i;
    endsequence
    property p_ready;
        hreadyout && !hresp;
    endproperty
    property p_unmapped;
        take && !hwrite && !mapped |=> hrdata == 32'h0;
    endproperty
    property p_ca_read;
        s_rd(`IDX_CONTROL_A) |=> hrdata[3:2] == 2'h0 && hrdata[31:8] == 24'h0;
    endproperty
    property p_cb_back;
        logic [7:0] v;
        s_wr(`IDX_CONTROL_B) ##1 (1, v = hwdata[7:0]) ##2 s_rd(`IDX_CONTROL_B)
            |=> hrdata == {24'h0, v & `CTLB_RW_MASK};
    endproperty
    property p_mask_off;
        s_wr(`IDX_INT_MASK) ##1 hwdata[3:0] == 4'h0 |-> ##2 !irq;
    endproperty
    property p_cap_edge;
        arm && !filt && !top_cap && (rise ? $rose(capture_input_pin) : $fell(capture_input_pin))
            |-> ##[2:5] irq;
    endproperty
    property p_wrong_edge;
        arm && !filt && !top_cap && (rise ? $fell(capture_input_pin) : $rose(capture_input_pin))
            |-> (!irq) [*6];
    endproperty
    property p_filt_late;
        arm && filt && rise && !top_cap && $rose(capture_input_pin) |-> (!irq) [*5];
    endproperty
    property p_filt_pass;
        arm && filt && rise && !top_cap && $rose(capture_input_pin) ##1 capture_input_pin [*7]
            |-> ##[0:3] irq;
    endproperty
    property p_top_off;
        arm && top_cap && $changed(capture_input_pin) |-> (!irq) [*6];
    endproperty
    a_ready: assert property (p_ready) else $error("bus answer not ready or not okay");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ca_read: assert property (p_ca_read) else $error("control a spare bits not zero");
    a_cb_back: assert property (p_cb_back) else $error("control b readback wrong");
    a_mask_off: assert property (p_mask_off) else $error("irq high with mask clear");
    a_cap_edge: assert property (p_cap_edge) else $error("capture gave no irq");
    a_wrong_edge: assert property (p_wrong_edge) else $error("wrong edge captured");
    a_filt_late: assert property (p_filt_late) else $error("filtered capture early");
    a_filt_pass: assert property (p_filt_pass) else $error("filtered capture lost");
    a_top_off: assert property (p_top_off) else $error("capture while top source");
endmodule // timer16_properties

// file: tb/capture_pin_model.sv
// behavioural source driving the capture input pin
`timescale 1ns/1ps
module capture_pin_model (
    input wire logic hclk,
    output logic capture_input_pin
);
    // ==========================================
    // level moves just after an edge, then holds for a set number of edges
    initial capture_input_pin = 1'b0;
    task drive(input logic lvl, input int hold);
        @(posedge hclk);
        capture_input_pin <= lvl;
        repeat (hold) @(posedge hclk);
    endtask
endmodule // capture_pin_model

// file: tb/timer16_mode_and_capture_ctrl_tb.sv
// self-checking bench for the 16-bit timer mode and capture block
`timescale 1ns/1ps
`include "timer16_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module timer16_mode_and_capture_ctrl_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] q;
    logic [15:0] t;
    logic [3:0] m;
    logic ext_clk = 1'b0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, pin;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int modes[15] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15};
    int divs[5] = '{1, 8, 64, 256, 1024};
    timer16_mode_and_capture_ctrl uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .capture_input_pin(pin), .ext_clock_pin(ext_clk), .irq(irq)
    );
    capture_pin_model pin_src (.hclk(hclk), .capture_input_pin(pin));
    always #2 hclk = ~hclk;
    // ==========================================
    // bus tasks: single word transfer, waits on ready, never assumes latency
    task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task rd(input logic [7:0] idx);
        bus(1'b0, idx, 32'h0);
    endtask
    // stop first so the counter is loaded while frozen, then start
    task setup(input logic [3:0] md, input logic [15:0] c, input logic [2:0] cs,
               input logic [1:0] fe);
        wr(`IDX_CONTROL_B, {27'h0, md[3:2], 3'h0});
        wr(`IDX_CONTROL_A, {30'h0, md[1:0]});
        wr(`IDX_COUNTER, {16'h0, c});
        wr(`IDX_INT_STATUS, 32'hF);
        wr(`IDX_CONTROL_B, {24'h0, fe, 1'b0, md[3:2], cs});
    endtask
    task close_out;
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // hang guard, well above the expected run of about 7400 cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out;
        end
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`IDX_CONTROL_B);
        `CHK("ctl_b_reset", 32'h0, q)
        rd(8'hF0);
        `CHK("unmapped", 32'h0, q)
        wr(`IDX_CONTROL_B, 32'hFF);
        rd(`IDX_CONTROL_B);
        `CHK("ctl_b_rw", 32'hDF, q)
        wr(`IDX_CONTROL_A, 32'hFF);
        rd(`IDX_CONTROL_A);
        `CHK("ctl_a_rw", 32'hF3, q)
        // top sources for the register-defined modes
        wr(`IDX_CONTROL_A, 32'h0);
        wr(`IDX_CONTROL_B, 32'h0);
        wr(`IDX_COMPARE_A, 32'h20);
        wr(`IDX_CAPTURE, 32'h20);
        foreach (modes[i]) begin
            m = modes[i][3:0];
            t = (m == 4'h0) ? `TOP_MAX : (m[3] || m == 4'h4) ? 16'h0020 :
                (m[1:0] == 2'h1) ? `TOP_8BIT : (m[1:0] == 2'h2) ? `TOP_9BIT : `TOP_10BIT;
            setup(m, (m == 4'h0) ? 16'hFFF0 : t - 16'h000F, `CS_DIV1, 2'h0);
            repeat (80) @(posedge hclk);
            wr(`IDX_CONTROL_B, {27'h0, m[3:2], 3'h0});
            rd(`IDX_COUNTER);
            `CHK("count_le_top", 1'b1, q[15:0] <= t)
            rd(`IDX_INT_STATUS);
            `CHK("overflow", (m == 4'h0 || (m > 4'h4 && m != 4'hC)), q[0])
        end
        for (int i = 0; i < 5; i++) begin
            setup(4'h0, 16'h0, 3'(i + 1), 2'h0);
            repeat (4 * divs[i]) @(posedge hclk);
            wr(`IDX_CONTROL_B, 32'h0);
            rd(`IDX_COUNTER);
            `CHK("prescaled", 1'b1, q[15:0] >= 16'h3 && q[15:0] <= 5 + 12 / divs[i])
        end
        // external pin: five pulses, counted on either edge
        for (int k = `CS_EXT_FALL; k <= `CS_EXT_RISE; k++) begin
            setup(4'h0, 16'h0, 3'(k), 2'h0);
            repeat (5) begin
                @(posedge hclk) ext_clk <= 1'b1;
                @(posedge hclk) ext_clk <= 1'b0;
            end
            wr(`IDX_CONTROL_B, 32'h0);
            rd(`IDX_COUNTER);
            `CHK("ext_edges", 32'h5, q)
        end
        // capture with a frozen counter so the copied value is exact
        wr(`IDX_INT_MASK, 32'h2);
        setup(4'h0, 16'h1234, `CS_STOP, 2'h1);
        pin_src.drive(1'b1, 10);
        rd(`IDX_CAPTURE);
        `CHK("capture", 32'h1234, q)
        rd(`IDX_INT_STATUS);
        `CHK("cap_flag", 32'h2, q)
        `CHK("cap_irq", 1'b1, irq)
        setup(4'h0, 16'h2345, `CS_STOP, 2'h1);
        pin_src.drive(1'b0, 10);
        rd(`IDX_INT_STATUS);
        `CHK("fall_ignored", 32'h0, q)
        setup(4'h0, 16'h2345, `CS_STOP, 2'h0);
        pin_src.drive(1'b1, 10);
        pin_src.drive(1'b0, 10);
        rd(`IDX_CAPTURE);
        `CHK("fall_capture", 32'h2345, q)
        // a three-sample pulse must not pass the filter
        setup(4'h0, 16'h3456, `CS_STOP, 2'h3);
        pin_src.drive(1'b1, 2);
        pin_src.drive(1'b0, 10);
        rd(`IDX_INT_STATUS);
        `CHK("glitch", 32'h0, q)
        pin_src.drive(1'b1, 14);
        rd(`IDX_CAPTURE);
        `CHK("filtered", 32'h3456, q)
        wr(`IDX_INT_MASK, 32'h0);
        rd(`IDX_INT_STATUS);
        `CHK("sticky", 32'h2, q)
        `CHK("masked_irq", 1'b0, irq)
        wr(`IDX_INT_MASK, 32'h2);
        rd(`IDX_INT_STATUS);
        `CHK("unmasked_irq", 1'b1, irq)
        wr(`IDX_INT_STATUS, 32'h2);
        rd(`IDX_INT_STATUS);
        `CHK("cleared", 32'h0, q)
        `CHK("cleared_irq", 1'b0, irq)
        // mode 12: the capture register is top, the pin is cut off
        setup(4'hC, 16'h4567, `CS_STOP, 2'h1);
        pin_src.drive(1'b0, 6);
        pin_src.drive(1'b1, 10);
        rd(`IDX_INT_STATUS);
        `CHK("top_no_flag", 32'h0, q)
        rd(`IDX_CAPTURE);
        `CHK("top_no_copy", 32'h3456, q)
        close_out;
    end
endmodule // timer16_mode_and_capture_ctrl_tb
bind timer16_mode_and_capture_ctrl timer16_properties chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_input_pin(capture_input_pin), .irq(irq)
);
